// ### design/fsp_map.svh
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

// Register byte offsets on the bus
`define FSP_OFF_CTRL 8'h00
`define FSP_OFF_PTR 8'h04
`define FSP_OFF_DATA 8'h08
`define FSP_OFF_SPM 8'h0c
`define FSP_OFF_LPM 8'h10
`define FSP_OFF_STAT 8'h14
`define FSP_OFF_MASK 8'h18
`define FSP_OFF_INFO 8'h1c

// Control register fields
`define FSP_CTRL_EN 0
`define FSP_CTRL_ERS 1
`define FSP_CTRL_WRT 2
`define FSP_CTRL_LCK 3
`define FSP_CTRL_RRE 4
`define FSP_CTRL_RBSY 5
`define FSP_CTRL_RST 5'h00

// Status and mask fields
`define FSP_STAT_DONE 0
`define FSP_STAT_TOUT 1
`define FSP_STAT_REFUSE 2
`define FSP_STAT_RST 3'h0

// Info register fields
`define FSP_INFO_FUSE_LSB 16
`define FSP_INFO_FUSE_MSB 17
`define FSP_INFO_IN_BOOT 18
`define FSP_INFO_IN_RWW 19

// Flash geometry in words
`define FSP_PC_W 15
`define FSP_WORD_W 7
`define FSP_HALTING_WRITE_REGION_START 15'h7000
`define FSP_BOOT_START_512 15'h7e00
`define FSP_BOOT_START_1K 15'h7c00
`define FSP_BOOT_START_2K 15'h7800
`define FSP_BOOT_START_4K 15'h7000
`define FSP_FUSE_512 2'b11
`define FSP_FUSE_1K 2'b10
`define FSP_FUSE_2K 2'b01

// Timing
`define FSP_PROG_MIN_US 3700
`define FSP_PROG_MAX_US 4500
`define FSP_RC_KHZ_DEF 1000
`define FSP_SPM_WINDOW 4

`endif

// ### design/fsp_pkg.sv
package fsp_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    FSP_ST_IDLE = 3'b001,
    FSP_ST_ARMED = 3'b010,
    FSP_ST_PROG = 3'b100
  } fsp_state_type;

  // Operation handed to the flash array
  typedef enum logic [2:0] {
    FSP_OP_NONE = 3'h0,
    FSP_OP_ERASE = 3'h1,
    FSP_OP_WRITE = 3'h2,
    FSP_OP_LOCK = 3'h3,
    FSP_OP_LOAD = 3'h4
  } fsp_op_type;

  typedef struct packed {
    fsp_op_type op;
    logic [7:0] page;
    logic [6:0] word;
    logic [15:0] data;
  } fsp_flash_cmd_type;

  // Sticky events, done in bit 0
  typedef struct packed {
    logic refused;
    logic timeout;
    logic done;
  } fsp_event_type;

endpackage

// ### design/fsp_op_timer.sv
`timescale 1ns/1ps
`include "fsp_map.svh"

module fsp_op_timer #(
  parameter int unsigned RC_KHZ = `FSP_RC_KHZ_DEF,
  parameter int unsigned CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic rc_tick_i,
  // Status
  output logic busy_o,
  output logic done_o
);

  // Start lands anywhere in a tick period, so one extra tick keeps the least time
  localparam int unsigned TICKS_RAW = (`FSP_PROG_MIN_US * RC_KHZ + 999) / 1000 + 1;
  localparam int unsigned TICKS = (TICKS_RAW == 0) ? 1 : TICKS_RAW;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(TICKS - 1);

  logic [CNT_W-1:0] cnt_reg;
  logic busy_reg;
  logic done_reg;
  wire cnt_last = cnt_reg == LAST;

  // Counts oscillator ticks only, so duration is clock-independent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= busy_reg && rc_tick_i && cnt_last;
      if (start_i && !busy_reg) begin
        busy_reg <= 1'b1;
        cnt_reg <= '0;
      end else if (busy_reg && rc_tick_i) begin
        if (cnt_last) begin
          busy_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;

  chk_timer_full_count: assert property (@(posedge clk_i) disable iff (rst_i)
    done_reg |-> $past(cnt_reg) == LAST && $past(busy_reg))
    else $error("operation ended before the full tick count");

  chk_timer_rc_paced: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_reg && !rc_tick_i |=> cnt_reg == $past(cnt_reg) && !done_reg)
    else $error("timer advanced without an oscillator tick");

endmodule

// ### design/fsp_addr_decode.sv
`timescale 1ns/1ps
`include "fsp_map.svh"

module fsp_addr_decode (
  // Inputs
  input wire logic [15:0] ptr_i,
  input wire logic [14:0] fetch_i,
  input wire logic [1:0] fuse_i,
  // Decoded fields
  output logic [7:0] page_o,
  output logic [6:0] word_o,
  output logic byte_hi_o,
  output logic [14:0] flash_word_o,
  output logic [14:0] boot_start_o,
  output logic ptr_in_boot_o,
  output logic ptr_in_rww_o,
  output logic fetch_in_rww_o
);

  // Bit 0 picks the byte, so word address sits one bit up
  assign flash_word_o = ptr_i[`FSP_PC_W:1];
  assign page_o = ptr_i[`FSP_PC_W:`FSP_WORD_W+1];
  assign word_o = ptr_i[`FSP_WORD_W:1];
  assign byte_hi_o = ptr_i[0];

  // Boot section start from the fuse pair
  assign boot_start_o = (fuse_i == `FSP_FUSE_512) ? `FSP_BOOT_START_512 :
                        (fuse_i == `FSP_FUSE_1K) ? `FSP_BOOT_START_1K :
                        (fuse_i == `FSP_FUSE_2K) ? `FSP_BOOT_START_2K :
                        `FSP_BOOT_START_4K;
  assign ptr_in_boot_o = flash_word_o >= boot_start_o;

  // Fixed split, whatever the boot size
  assign ptr_in_rww_o = flash_word_o < `FSP_HALTING_WRITE_REGION_START;
  assign fetch_in_rww_o = fetch_i < `FSP_HALTING_WRITE_REGION_START;

endmodule

// ### design/fsp_self_prog_top.sv
`timescale 1ns/1ps
`include "fsp_map.svh"

// What this block does
// - Erase and write durations are counted on internal RC oscillator ticks
// - Erase, page write and lock write last between 3.7 and 4.5 ms
// - Two boot-size fuse bits select boot start 0x7E00, 0x7C00, 0x7800 or 0x7000
// - Words 0x0000-0x6FFF form the readable region, 0x7000-0x7FFF the halting one
// - Flash word address is fifteen bits wide
// - A page holds 128 words; low seven address bits pick the word
// - Pointer bits fifteen to eight give the page for erase and write
// - Pointer bit zero is zero for stores; selects byte for program reads
// - During erase or write only the halting region may be read
// - Region busy flag stays set until the region is made readable again
// - Enable plus one selector picks erase, write, lock write or re-enable; enable alone loads the buffer
// - EEPROM write in progress blocks all flash programming
// - Store must follow control write within four cycles, else bits clear
module fsp_self_prog_top #(
  parameter int unsigned RC_KHZ = `FSP_RC_KHZ_DEF,
  parameter int unsigned SPM_WINDOW = `FSP_SPM_WINDOW
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq_o,
  // Device status and straps
  input wire logic eeprom_write_busy_i,
  input wire logic [1:0] boot_size_fuse_i,
  input wire logic rc_tick_i,
  // Instruction fetch guard
  input wire logic [14:0] fetch_addr_i,
  output logic fetch_blocked_o,
  // Flash array
  input wire logic [15:0] flash_rdata_i,
  output logic [14:0] flash_raddr_o,
  output fsp_pkg::fsp_flash_cmd_type flash_cmd_o,
  output logic flash_load_o,
  output logic flash_busy_o
);

  localparam int unsigned WIN_W = $clog2(SPM_WINDOW + 1);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(SPM_WINDOW - 1);

  fsp_pkg::fsp_state_type state_reg;
  fsp_pkg::fsp_state_type state_next;
  fsp_pkg::fsp_flash_cmd_type cmd_reg;
  fsp_pkg::fsp_flash_cmd_type cmd_next;
  fsp_pkg::fsp_event_type ev;
  logic [`FSP_CTRL_RRE:0] ctrl_reg;
  logic [`FSP_CTRL_RRE:0] ctrl_next;
  logic rbusy_reg;
  logic rbusy_next;
  logic [WIN_W-1:0] win_reg;
  logic [WIN_W-1:0] win_next;
  logic [15:0] ptr_reg;
  logic [15:0] data_reg;
  logic [2:0] stat_reg;
  logic [2:0] stat_next;
  logic [2:0] mask_reg;
  logic [2:0] mask_next;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic irq_reg;
  logic load_reg;
  logic load_next;
  logic blocked_reg;
  logic [14:0] raddr_reg;
  logic timer_start;
  logic timer_busy;
  logic timer_done;
  logic sel_ctrl;
  logic sel_ptr;
  logic sel_data;
  logic sel_spm;
  logic sel_lpm;
  logic sel_stat;
  logic sel_mask;
  logic sel_info;
  logic [31:0] rd_data;

  logic [7:0] page_w;
  logic [6:0] word_w;
  logic byte_hi_w;
  logic [14:0] flash_word_w;
  logic [14:0] boot_start_w;
  logic in_boot_w;
  logic in_rww_w;
  logic fetch_rww_w;

  fsp_addr_decode u_decode (
    .ptr_i(ptr_reg),
    .fetch_i(fetch_addr_i),
    .fuse_i(boot_size_fuse_i),
    .page_o(page_w),
    .word_o(word_w),
    .byte_hi_o(byte_hi_w),
    .flash_word_o(flash_word_w),
    .boot_start_o(boot_start_w),
    .ptr_in_boot_o(in_boot_w),
    .ptr_in_rww_o(in_rww_w),
    .fetch_in_rww_o(fetch_rww_w)
  );

  fsp_op_timer #(
    .RC_KHZ(RC_KHZ)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(timer_start),
    .rc_tick_i(rc_tick_i),
    .busy_o(timer_busy),
    .done_o(timer_done)
  );

  // Bus request qualifiers; ack_reg blocks a second take of the same cycle
  wire req_w = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr_w = req_w && wb_we_i;
  wire rd_w = req_w && !wb_we_i;

  // Address decode
  always_comb begin
    sel_ctrl = 1'b0;
    sel_ptr = 1'b0;
    sel_data = 1'b0;
    sel_spm = 1'b0;
    sel_lpm = 1'b0;
    sel_stat = 1'b0;
    sel_mask = 1'b0;
    sel_info = 1'b0;
    if (wb_adr_i == `FSP_OFF_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (wb_adr_i == `FSP_OFF_PTR) begin
      sel_ptr = 1'b1;
    end else if (wb_adr_i == `FSP_OFF_DATA) begin
      sel_data = 1'b1;
    end else if (wb_adr_i == `FSP_OFF_SPM) begin
      sel_spm = 1'b1;
    end else if (wb_adr_i == `FSP_OFF_LPM) begin
      sel_lpm = 1'b1;
    end else if (wb_adr_i == `FSP_OFF_STAT) begin
      sel_stat = 1'b1;
    end else if (wb_adr_i == `FSP_OFF_MASK) begin
      sel_mask = 1'b1;
    end else if (wb_adr_i == `FSP_OFF_INFO) begin
      sel_info = 1'b1;
    end
  end

  // Named write strobes; control and store need byte lane 0
  wire ctrl_wr = wr_w && sel_ctrl && wb_sel_i[0];
  wire spm_wr = wr_w && sel_spm && wb_sel_i[0];
  wire [2:0] stat_clr = (wr_w && sel_stat && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;
  wire [`FSP_CTRL_RRE:0] ctrl_wdata = wb_dat_i[`FSP_CTRL_RRE:0];
  wire ctrl_arm = ctrl_wdata[`FSP_CTRL_EN];

  // Program read is blocked while the busy region is addressed
  wire lpm_blocked = rbusy_reg && in_rww_w;
  wire [7:0] lpm_byte = byte_hi_w ? flash_rdata_i[15:8] : flash_rdata_i[7:0];

  // Read data mux; unmapped reads return zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_data[`FSP_CTRL_RRE:0] = ctrl_reg;
      rd_data[`FSP_CTRL_RBSY] = rbusy_reg;
    end else if (sel_ptr) begin
      rd_data[15:0] = ptr_reg;
    end else if (sel_data) begin
      rd_data[15:0] = data_reg;
    end else if (sel_lpm) begin
      rd_data[7:0] = lpm_blocked ? 8'h00 : lpm_byte;
    end else if (sel_stat) begin
      rd_data[2:0] = stat_reg;
    end else if (sel_mask) begin
      rd_data[2:0] = mask_reg;
    end else if (sel_info) begin
      rd_data[14:0] = boot_start_w;
      rd_data[`FSP_INFO_FUSE_MSB:`FSP_INFO_FUSE_LSB] = boot_size_fuse_i;
      rd_data[`FSP_INFO_IN_BOOT] = in_boot_w;
      rd_data[`FSP_INFO_IN_RWW] = in_rww_w;
    end
  end

  // Sequencer: arm on control write, act on store within the window
  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    rbusy_next = rbusy_reg;
    win_next = win_reg;
    cmd_next = cmd_reg;
    load_next = 1'b0;
    timer_start = 1'b0;
    ev = '0;
    case (state_reg)
      fsp_pkg::FSP_ST_IDLE: begin
        // Writes while busy are dropped; software polls enable first
        if (ctrl_wr) begin
          if (ctrl_arm && eeprom_write_busy_i) begin
            ev.refused = 1'b1;
          end else begin
            ctrl_next = ctrl_wdata;
            if (ctrl_arm) begin
              state_next = fsp_pkg::FSP_ST_ARMED;
              win_next = '0;
            end
          end
        end
      end
      fsp_pkg::FSP_ST_ARMED: begin
        if (spm_wr && eeprom_write_busy_i) begin
          ctrl_next = `FSP_CTRL_RST;
          ev.refused = 1'b1;
          state_next = fsp_pkg::FSP_ST_IDLE;
        end else if (spm_wr) begin
          cmd_next.page = page_w;
          cmd_next.word = word_w;
          cmd_next.data = data_reg;
          if (ctrl_reg[`FSP_CTRL_ERS] || ctrl_reg[`FSP_CTRL_WRT]) begin
            cmd_next.op = ctrl_reg[`FSP_CTRL_ERS] ? fsp_pkg::FSP_OP_ERASE :
                                                     fsp_pkg::FSP_OP_WRITE;
            timer_start = 1'b1;
            rbusy_next = 1'b1;
            state_next = fsp_pkg::FSP_ST_PROG;
          end else if (ctrl_reg[`FSP_CTRL_LCK]) begin
            // Lock write leaves the region busy flag as it was, so it blocks no reads of its own
            cmd_next.op = fsp_pkg::FSP_OP_LOCK;
            timer_start = 1'b1;
            state_next = fsp_pkg::FSP_ST_PROG;
          end else if (ctrl_reg[`FSP_CTRL_RRE]) begin
            rbusy_next = 1'b0;
            ctrl_next = `FSP_CTRL_RST;
            ev.done = 1'b1;
            state_next = fsp_pkg::FSP_ST_IDLE;
          end else begin
            cmd_next.op = fsp_pkg::FSP_OP_LOAD;
            load_next = 1'b1;
            ctrl_next = `FSP_CTRL_RST;
            ev.done = 1'b1;
            state_next = fsp_pkg::FSP_ST_IDLE;
          end
        end else if (win_reg == WIN_LAST) begin
          ctrl_next = `FSP_CTRL_RST;
          ev.timeout = 1'b1;
          state_next = fsp_pkg::FSP_ST_IDLE;
        end else begin
          win_next = win_reg + 1'b1;
        end
      end
      fsp_pkg::FSP_ST_PROG: begin
        // Enable stays high until the timed operation ends
        if (timer_done) begin
          ctrl_next = `FSP_CTRL_RST;
          cmd_next.op = fsp_pkg::FSP_OP_NONE;
          ev.done = 1'b1;
          state_next = fsp_pkg::FSP_ST_IDLE;
        end
      end
      default: begin
        ctrl_next = `FSP_CTRL_RST;
        state_next = fsp_pkg::FSP_ST_IDLE;
      end
    endcase
  end

  // Sticky status: a new event wins over a same-cycle clear
  assign stat_next = (stat_reg & ~stat_clr) | ev;
  assign mask_next = (wr_w && sel_mask && wb_sel_i[0]) ? wb_dat_i[2:0] : mask_reg;

  // Sequencer and flash-facing registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= fsp_pkg::FSP_ST_IDLE;
      ctrl_reg <= `FSP_CTRL_RST;
      rbusy_reg <= 1'b0;
      win_reg <= '0;
      cmd_reg <= '0;
      load_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      rbusy_reg <= rbusy_next;
      win_reg <= win_next;
      cmd_reg <= cmd_next;
      load_reg <= load_next;
    end
  end

  // Software-visible registers and bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_reg <= 16'h0000;
      data_reg <= 16'h0000;
      stat_reg <= `FSP_STAT_RST;
      mask_reg <= `FSP_STAT_RST;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      if (wr_w && sel_ptr && wb_sel_i[0]) ptr_reg[7:0] <= wb_dat_i[7:0];
      if (wr_w && sel_ptr && wb_sel_i[1]) ptr_reg[15:8] <= wb_dat_i[15:8];
      if (wr_w && sel_data && wb_sel_i[0]) data_reg[7:0] <= wb_dat_i[7:0];
      if (wr_w && sel_data && wb_sel_i[1]) data_reg[15:8] <= wb_dat_i[15:8];
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      ack_reg <= req_w;
      if (rd_w) dat_reg <= rd_data;
      irq_reg <= |(stat_next & mask_next);
    end
  end

  // Fetch guard and read address; one cycle behind the addresses, guard in step with the busy flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blocked_reg <= 1'b0;
      raddr_reg <= 15'h0000;
    end else begin
      blocked_reg <= rbusy_next && fetch_rww_w;
      raddr_reg <= flash_word_w;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = irq_reg;
  assign fetch_blocked_o = blocked_reg;
  assign flash_raddr_o = raddr_reg;
  assign flash_cmd_o = cmd_reg;
  assign flash_load_o = load_reg;
  assign flash_busy_o = timer_busy;

  chk_window_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == fsp_pkg::FSP_ST_ARMED && win_reg == WIN_LAST && !spm_wr
    |=> state_reg == fsp_pkg::FSP_ST_IDLE && !ctrl_reg[`FSP_CTRL_EN] && stat_reg[`FSP_STAT_TOUT])
    else $error("armed command not dropped at window end");

  chk_window_length: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_reg == fsp_pkg::FSP_ST_ARMED) && !spm_wr ##1 !spm_wr ##1 !spm_wr ##1 !spm_wr
    |=> state_reg == fsp_pkg::FSP_ST_IDLE)
    else $error("armed window not four cycles");

  chk_busy_on_start: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == fsp_pkg::FSP_ST_ARMED && spm_wr && !eeprom_write_busy_i
    && (ctrl_reg[`FSP_CTRL_ERS] || ctrl_reg[`FSP_CTRL_WRT])
    |=> rbusy_reg && flash_busy_o && ctrl_reg[`FSP_CTRL_EN])
    else $error("erase or write did not raise busy");

  chk_busy_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    rbusy_reg && !(state_reg == fsp_pkg::FSP_ST_ARMED && spm_wr) |=> rbusy_reg)
    else $error("region busy dropped without re-enable");

  chk_eeprom_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == fsp_pkg::FSP_ST_IDLE && ctrl_wr && ctrl_arm && eeprom_write_busy_i
    |=> state_reg == fsp_pkg::FSP_ST_IDLE && stat_reg[`FSP_STAT_REFUSE])
    else $error("programming armed during EEPROM write");

  chk_fetch_guard: assert property (@(posedge clk_i) disable iff (rst_i)
    fetch_rww_w |=> fetch_blocked_o == rbusy_reg)
    else $error("fetch of busy region not blocked");

  chk_lpm_guard: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_w && sel_lpm && lpm_blocked |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("busy region readable during programming");

  chk_enable_done: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == fsp_pkg::FSP_ST_PROG && timer_done
    |=> !ctrl_reg[`FSP_CTRL_EN] && stat_reg[`FSP_STAT_DONE] && !flash_busy_o)
    else $error("enable not cleared at end of operation");

  chk_boot_start: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_w && sel_info && boot_size_fuse_i == `FSP_FUSE_512
    |=> wb_dat_o[14:0] == `FSP_BOOT_START_512)
    else $error("boot start wrong for smallest boot size");

  chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    |(stat_reg & mask_reg) |-> irq_o)
    else $error("interrupt low with unmasked status set");

endmodule

// ### bench/fsp_flash_model.sv
`timescale 1ns/1ps

module fsp_flash_model #(
  parameter int unsigned TICK_DIV = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Array read port
  input wire logic [14:0] flash_raddr_i,
  output logic [15:0] flash_rdata_o,
  // Oscillator
  output logic rc_tick_o
);
  int unsigned div_reg;

  // Content follows the address so every read is predictable
  assign flash_rdata_o = {1'b1, flash_raddr_i};

  // Slow oscillator stand-in, free running, unrelated to bus traffic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 0;
      rc_tick_o <= 1'b0;
    end else begin
      div_reg <= (div_reg == TICK_DIV - 1) ? 0 : div_reg + 1;
      rc_tick_o <= (div_reg == TICK_DIV - 1);
    end
  end
endmodule

// ### bench/test_fsp_self_prog_top.sv
`timescale 1ns/1ps
`include "fsp_map.svh"

module test_fsp_self_prog_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, irq_o, fetch_blocked_o, flash_load_o, flash_busy_o, rc_tick;
  logic eeprom_busy = 1'b0;
  logic [1:0] fuse = 2'b00;
  logic [14:0] fetch_addr = 15'h0010, flash_raddr_o;
  logic [15:0] flash_rdata;
  fsp_pkg::fsp_flash_cmd_type flash_cmd_o;
  logic [14:0] starts [4] = '{15'h7000, 15'h7800, 15'h7c00, 15'h7e00};
  logic [2:0] op_seen = 3'h0;
  logic [6:0] load_word = 7'h00;
  logic [15:0] load_data = 16'h0;
  logic load_seen = 1'b0;
  int ticks = 0, cycles = 0, fails = 0, total_checks = 0;

  fsp_self_prog_top #(.RC_KHZ(1), .SPM_WINDOW(4)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .eeprom_write_busy_i(eeprom_busy), .boot_size_fuse_i(fuse),
    .rc_tick_i(rc_tick), .fetch_addr_i(fetch_addr), .fetch_blocked_o(fetch_blocked_o),
    .flash_rdata_i(flash_rdata), .flash_raddr_o(flash_raddr_o), .flash_cmd_o(flash_cmd_o),
    .flash_load_o(flash_load_o), .flash_busy_o(flash_busy_o));

  fsp_flash_model #(.TICK_DIV(10)) partner (.clk_i(clk_i), .rst_i(rst_i),
    .flash_raddr_i(flash_raddr_o), .flash_rdata_o(flash_rdata), .rc_tick_o(rc_tick));

  always #5 clk_i = ~clk_i;

  // Watch the array side; load pulses last one cycle so they are latched here
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (flash_busy_o === 1'b1) begin
      op_seen <= flash_cmd_o.op;
      if (rc_tick === 1'b1) ticks <= ticks + 1;
    end
    if (flash_load_o === 1'b1) begin
      load_seen <= 1'b1;
      load_word <= flash_cmd_o.word;
      load_data <= flash_cmd_o.data;
    end
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wb_acc(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) check("ack", 0, 1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_acc(1'b1, adr, dat);
  endtask

  task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    wb_acc(1'b0, adr, 32'h0);
    check(what, rd, exp);
  endtask

  // Poll control until enable drops; no new command goes out before that
  task automatic wait_en();
    int n;
    n = 0;
    do begin
      wb_acc(1'b0, `FSP_OFF_CTRL, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    check("enable clear", rd[0], 0);
  endtask

  // Control write then store straight after, then poll
  task automatic cmd(input logic [31:0] ctrl);
    wr(`FSP_OFF_CTRL, ctrl);
    wr(`FSP_OFF_SPM, 32'h0);
    wait_en();
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("ctrl rst", `FSP_OFF_CTRL, 0);
    rdchk("stat rst", `FSP_OFF_STAT, 0);
    wr(8'h20, 32'hffff);
    rdchk("unmapped", 8'h20, 0);
    $display("reset test done");
    // Every fuse pair, pointer at both sides of the region limit
    for (int i = 0; i < 4; i++) begin
      fuse <= 2'(i);
      wr(`FSP_OFF_PTR, 32'he000);
      rdchk("info top", `FSP_OFF_INFO, {12'h0, 1'b0, i == 0, 2'(i), 1'b0, starts[i]});
      wr(`FSP_OFF_PTR, 32'hdffe);
      rdchk("info low", `FSP_OFF_INFO, {12'h0, 1'b1, 1'b0, 2'(i), 1'b0, starts[i]});
    end
    $display("map test done");
    // Page erase with timing, region block and interrupt
    wr(`FSP_OFF_MASK, 32'h1);
    wr(`FSP_OFF_PTR, 32'h1200);
    ticks = 0;
    wr(`FSP_OFF_CTRL, 32'h3);
    wr(`FSP_OFF_SPM, 32'h0);
    check("busy", flash_busy_o, 1);
    check("op erase", flash_cmd_o.op, 1);
    check("page", flash_cmd_o.page, 8'h12);
    check("fetch low", fetch_blocked_o, 1);
    rdchk("rww busy", `FSP_OFF_CTRL, 32'h23);
    rdchk("lpm blocked", `FSP_OFF_LPM, 0);
    wait_en();
    check("ticks", ticks, 5);
    check("irq", irq_o, 1);
    rdchk("done", `FSP_OFF_STAT, 1);
    wr(`FSP_OFF_STAT, 32'h1);
    check("irq off", irq_o, 0);
    rdchk("busy kept", `FSP_OFF_CTRL, 32'h20);
    fetch_addr <= 15'h7000;
    repeat (2) @(posedge clk_i);
    check("fetch top", fetch_blocked_o, 0);
    fetch_addr <= 15'h0010;
    cmd(32'h11);
    rdchk("reenabled", `FSP_OFF_CTRL, 0);
    check("fetch free", fetch_blocked_o, 0);
    $display("erase test done");
    // Buffer load, page write and lock write
    wr(`FSP_OFF_PTR, 32'h0086);
    wr(`FSP_OFF_DATA, 32'hbeef);
    cmd(32'h1);
    check("load", load_seen, 1);
    check("load word", load_word, 7'h43);
    check("load data", load_data, 16'hbeef);
    wr(`FSP_OFF_PTR, 32'h3400);
    for (int i = 0; i < 2; i++) begin
      cmd(i == 0 ? 32'h5 : 32'h9);
      check("op", op_seen, i == 0 ? 2 : 3);
    end
    cmd(32'h11);
    $display("program test done");
    // Store too late, then control write during an EEPROM write
    wr(`FSP_OFF_STAT, 32'h7);
    wr(`FSP_OFF_CTRL, 32'h3);
    repeat (6) @(posedge clk_i);
    rdchk("late ctrl", `FSP_OFF_CTRL, 0);
    rdchk("late stat", `FSP_OFF_STAT, 32'h2);
    check("no irq", irq_o, 0);
    wr(`FSP_OFF_STAT, 32'h7);
    eeprom_busy <= 1'b1;
    wr(`FSP_OFF_CTRL, 32'h3);
    rdchk("ee ctrl", `FSP_OFF_CTRL, 0);
    rdchk("ee stat", `FSP_OFF_STAT, 32'h4);
    eeprom_busy <= 1'b0;
    // Armed first, then the store meets an EEPROM write
    wr(`FSP_OFF_STAT, 32'h7);
    wr(`FSP_OFF_CTRL, 32'h3);
    eeprom_busy <= 1'b1;
    wr(`FSP_OFF_SPM, 32'h0);
    eeprom_busy <= 1'b0;
    rdchk("ee store", `FSP_OFF_STAT, 32'h4);
    check("ee no busy", flash_busy_o, 0);
    rdchk("ee store ctrl", `FSP_OFF_CTRL, 0);
    $display("refusal test done");
    // Program reads pick a byte by pointer bit zero
    wr(`FSP_OFF_PTR, 32'he003);
    check("raddr", flash_raddr_o, 15'h7001);
    rdchk("lpm hi", `FSP_OFF_LPM, 32'hf0);
    wr(`FSP_OFF_PTR, 32'he002);
    rdchk("lpm lo", `FSP_OFF_LPM, 32'h01);
    // Lane 0 alone leaves the upper pointer byte in place
    wb_sel_i <= 4'h1;
    wr(`FSP_OFF_PTR, 32'h0000);
    wb_sel_i <= 4'h3;
    rdchk("ptr lane", `FSP_OFF_PTR, 32'he000);
    $display("read test done");
    close_out();
  end
endmodule
